//--- brc_regs.sv
// Buck rail control registers and rail control derivation
`timescale 1ns/100ps
module brc_regs (
  input wire logic clk,
  input wire logic resetn,
  input brc_pkg::brc_reg_request_type regRequest,
  output brc_pkg::brc_reg_answer_type regAnswer,
  input brc_pkg::brc_link_command_type setVoltageCommand,
  input wire logic [2:0] sequencerRequest,
  input wire logic resumeResetN,
  input wire logic platformResetN,
  input wire logic sleepVoltageOffAtZero,
  input wire logic [7:0] maxOutputLimitCode,
  output logic exitTypeReleased,
  output brc_pkg::brc_rail_status_type [2:0] railStatus
);
  import brc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [2:0][7:0] ctlReg, slewReg, bootReg, vidReg, seqReg;
  logic [2:0][7:0] next_ctlReg, next_slewReg, next_bootReg, next_vidReg, next_seqReg;
  logic [7:0] exitReg, next_exitReg;
  logic exitSeen, next_exitSeen;
  brc_reg_answer_type next_regAnswer;
  brc_rail_status_type [2:0] next_railStatus;

  function automatic logic [7:0] fixBoot(input logic [7:0] value);
    fixBoot = {value[7:1], |value[7:1]};
  endfunction

  function automatic logic [11:0] codeToMv(input logic [7:0] code, input logic link);
    logic [7:0] clipped;
    logic [7:0] base;
    clipped = (code > BRC_CODE_MAX) ? BRC_CODE_MAX : code;
    base = link ? BRC_LINK_CODE_BASE : BRC_DIRECT_CODE_BASE;
    if (clipped < base) begin
      clipped = base;
    end
    codeToMv = (link ? BRC_LINK_MV_BASE : BRC_DIRECT_MV_BASE)
      + 12'(BRC_STEP_MV * 12'(clipped - base));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and reads
  always_comb begin
    next_ctlReg = ctlReg;
    next_slewReg = slewReg;
    next_bootReg = bootReg;
    next_vidReg = vidReg;
    next_seqReg = seqReg;
    next_exitReg = exitReg;
    next_regAnswer.valid = regRequest.read;
    next_regAnswer.data = 8'h00;
    // Link updates first so a same-cycle register write overrides them
    for (int r = 0; r < BRC_RAILS; r++) begin
      if (setVoltageCommand.valid && setVoltageCommand.rail == 2'(r) && ctlReg[r][BRC_CTL_LINK_BIT]) begin
        next_vidReg[r] = setVoltageCommand.code;
      end
    end
    if (regRequest.write) begin
      if (regRequest.address == BRC_EXIT_OFS) begin
        next_exitReg = regRequest.data & BRC_EXIT_MASK;
      end
      for (int r = 0; r < BRC_RAILS; r++) begin
        if (regRequest.address == BRC_CTL_OFS[r]) begin
          next_ctlReg[r] = regRequest.data & BRC_CTL_MASK;
        end
        if (regRequest.address == BRC_SLEW_OFS[r]) begin
          next_slewReg[r] = regRequest.data & BRC_SLEW_MASK;
        end
        if (regRequest.address == BRC_BOOT_OFS[r]) begin
          next_bootReg[r] = fixBoot(regRequest.data);
        end
        if (regRequest.address == BRC_VID_OFS[r]) begin
          next_vidReg[r] = regRequest.data;
        end
        if (regRequest.address == BRC_SEQ_OFS[r]) begin
          next_seqReg[r] = regRequest.data & BRC_SEQ_MASK;
        end
      end
    end
    // Unmapped addresses read as zero
    if (regRequest.read) begin
      if (regRequest.address == BRC_EXIT_OFS) begin
        next_regAnswer.data = exitReg;
      end
      for (int r = 0; r < BRC_RAILS; r++) begin
        if (regRequest.address == BRC_CTL_OFS[r]) begin
          next_regAnswer.data = ctlReg[r];
        end
        if (regRequest.address == BRC_SLEW_OFS[r]) begin
          next_regAnswer.data = slewReg[r];
        end
        if (regRequest.address == BRC_BOOT_OFS[r]) begin
          next_regAnswer.data = bootReg[r];
        end
        if (regRequest.address == BRC_VID_OFS[r]) begin
          next_regAnswer.data = vidReg[r];
        end
        if (regRequest.address == BRC_SEQ_OFS[r]) begin
          next_regAnswer.data = seqReg[r];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctlReg <= BRC_CTL_RST;
      slewReg <= BRC_SLEW_RST;
      bootReg <= BRC_BOOT_RST;
      vidReg <= BRC_VID_RST;
      seqReg <= BRC_SEQ_RST;
      exitReg <= BRC_EXIT_RST;
      regAnswer <= '0;
    end else begin
      ctlReg <= next_ctlReg;
      slewReg <= next_slewReg;
      bootReg <= next_bootReg;
      vidReg <= next_vidReg;
      seqReg <= next_seqReg;
      exitReg <= next_exitReg;
      regAnswer <= next_regAnswer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Exit sequencing latch: set when resume and platform resets are both low; only resetn clears it
  always_comb begin
    next_exitSeen = exitSeen | (~resumeResetN & ~platformResetN);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      exitSeen <= 1'b0;
    end else begin
      exitSeen <= next_exitSeen;
    end
  end

  assign exitTypeReleased = exitSeen;

  ////////////////////////////////////////////////////////////////////////////
  // Per-rail control outputs, registered
  always_comb begin
    logic link;
    logic [7:0] code;
    link = 1'b0;
    code = 8'h00;
    for (int r = 0; r < BRC_RAILS; r++) begin
      link = ctlReg[r][BRC_CTL_LINK_BIT];
      code = vidReg[r];
      // Limit clamps only the link path; raising it unlocks 0xd3
      if (link && code > maxOutputLimitCode) begin
        code = maxOutputLimitCode;
      end
      next_railStatus[r].linkEnable = link;
      next_railStatus[r].voltageCode = code;
      next_railStatus[r].targetMv = codeToMv(code, link);
      if (ctlReg[r][BRC_CTL_SEL_BIT]) begin
        next_railStatus[r].railOn = ctlReg[r][BRC_CTL_EN_BIT];
      end else begin
        next_railStatus[r].railOn = sequencerRequest[r];
      end
      if (link && code == 8'h00 && sleepVoltageOffAtZero) begin
        next_railStatus[r].railOn = 1'b0;
      end
      unique case (slewReg[r][BRC_SLEW_FAST_LSB +: 2])
        2'b00: next_railStatus[r].fastRate = BRC_FAST_RATE_00;
        2'b01: next_railStatus[r].fastRate = BRC_FAST_RATE_01;
        2'b10: next_railStatus[r].fastRate = BRC_FAST_RATE_10;
        2'b11: next_railStatus[r].fastRate = BRC_FAST_RATE_00; // Reserved: slowest safe choice
      endcase
      next_railStatus[r].fastRateReserved = &slewReg[r][BRC_SLEW_FAST_LSB +: 2];
      next_railStatus[r].slowRate = slewReg[r][BRC_SLEW_SLOW_BIT] ? BRC_SLOW_RATE_1 : BRC_SLOW_RATE_0;
      next_railStatus[r].railClass = brc_rail_class_type'(seqReg[r][BRC_SEQ_TYPE_LSB +: 2]);
      // Exit sequencing exists only for rails 0 and 1
      if (r < 2 && exitReg[r] && !exitSeen) begin
        next_railStatus[r].railClass = BRC_TYPE_A;
      end
      next_railStatus[r].sequenceGroup = seqReg[r][BRC_SEQ_GROUP_LSB +: 4];
      next_railStatus[r].sequenceExcluded = seqReg[r][BRC_SEQ_GROUP_LSB +: 4] == BRC_GROUP_EXCLUDED;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      railStatus <= '0;
    end else begin
      railStatus <= next_railStatus;
    end
  end

endmodule

//--- brc_pkg.sv
// Constants and types for the buck rail control register bank
package brc_pkg;

  localparam int BRC_RAILS = 3;

  // Register offsets
  localparam logic [7:0] BRC_EXIT_OFS = 8'h10;
  localparam logic [2:0][7:0] BRC_CTL_OFS = {8'h5f, 8'h54, 8'h53};
  localparam logic [2:0][7:0] BRC_SLEW_OFS = {8'haa, 8'ha9, 8'ha8};
  localparam logic [2:0][7:0] BRC_BOOT_OFS = {8'hdc, 8'hcc, 8'hbc};
  localparam logic [2:0][7:0] BRC_VID_OFS = {8'hde, 8'hce, 8'hbe};
  localparam logic [2:0][7:0] BRC_SEQ_OFS = {8'he8, 8'he7, 8'he6};

  // Writable bit masks
  localparam logic [7:0] BRC_EXIT_MASK = 8'h03;
  localparam logic [7:0] BRC_CTL_MASK = 8'h13;
  localparam logic [7:0] BRC_SLEW_MASK = 8'h31;
  localparam logic [7:0] BRC_SEQ_MASK = 8'h3f;

  // Field positions
  localparam int BRC_CTL_EN_BIT = 0;
  localparam int BRC_CTL_SEL_BIT = 1;
  localparam int BRC_CTL_LINK_BIT = 4;
  localparam int BRC_SLEW_SLOW_BIT = 0;
  localparam int BRC_SLEW_FAST_LSB = 4;
  localparam int BRC_SEQ_GROUP_LSB = 0;
  localparam int BRC_SEQ_TYPE_LSB = 4;

  // Reset values; boot and sequencing defaults stand in for factory trim
  localparam logic [7:0] BRC_EXIT_RST = 8'h00;
  localparam logic [2:0][7:0] BRC_CTL_RST = {8'h00, 8'h10, 8'h10};
  localparam logic [2:0][7:0] BRC_SLEW_RST = {8'h10, 8'h00, 8'h00};
  localparam logic [2:0][7:0] BRC_BOOT_RST = {8'h97, 8'h97, 8'h97};
  localparam logic [2:0][7:0] BRC_VID_RST = {8'hdd, 8'h97, 8'h97};
  localparam logic [2:0][7:0] BRC_SEQ_RST = {8'h00, 8'h00, 8'h00};

  // Voltage code mapping, millivolts
  localparam logic [7:0] BRC_CODE_MAX = 8'hd3;
  localparam logic [7:0] BRC_LINK_CODE_BASE = 8'h01;
  localparam logic [7:0] BRC_DIRECT_CODE_BASE = 8'h33;
  localparam logic [11:0] BRC_LINK_MV_BASE = 12'd250;
  localparam logic [11:0] BRC_DIRECT_MV_BASE = 12'd1100;
  localparam logic [11:0] BRC_STEP_MV = 12'd5;
  localparam logic [3:0] BRC_GROUP_EXCLUDED = 4'hf;

  // Slew rates in tenths of mV/us
  localparam logic [9:0] BRC_FAST_RATE_00 = 10'd100;
  localparam logic [9:0] BRC_FAST_RATE_01 = 10'd200;
  localparam logic [9:0] BRC_FAST_RATE_10 = 10'd400;
  localparam logic [9:0] BRC_SLOW_RATE_0 = 10'd25;
  localparam logic [9:0] BRC_SLOW_RATE_1 = 10'd50;

  typedef enum logic [1:0] {
    BRC_TYPE_A = 2'b00,
    BRC_TYPE_U = 2'b01,
    BRC_TYPE_S = 2'b10,
    BRC_TYPE_SX = 2'b11
  } brc_rail_class_type;

  typedef struct packed {
    logic railOn;
    logic linkEnable;
    logic [7:0] voltageCode;
    logic [11:0] targetMv;
    logic [9:0] fastRate;
    logic [9:0] slowRate;
    logic fastRateReserved;
    brc_rail_class_type railClass;
    logic [3:0] sequenceGroup;
    logic sequenceExcluded;
  } brc_rail_status_type;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] address;
    logic [7:0] data;
  } brc_reg_request_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } brc_reg_answer_type;

  typedef struct packed {
    logic valid;
    logic [1:0] rail;
    logic [7:0] code;
  } brc_link_command_type;

endpackage

//--- brc_properties.sv
// Port checker for the buck rail control register bank
`timescale 1ns/100ps
module brc_properties
  import brc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input brc_pkg::brc_reg_request_type regRequest,
  input brc_pkg::brc_reg_answer_type regAnswer,
  input wire logic resumeResetN,
  input wire logic platformResetN,
  input wire logic sleepVoltageOffAtZero,
  input wire logic exitTypeReleased,
  input brc_pkg::brc_rail_status_type [2:0] railStatus
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_answer;
    regAnswer.valid == $past(regRequest.read);
  endproperty
  a_answer: assert property (p_answer) else $error("read answer timing wrong");
  property p_unmapped;
    regRequest.read && regRequest.address == 8'h00 |=> regAnswer.data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_exit_set;
    !resumeResetN && !platformResetN |=> exitTypeReleased;
  endproperty
  a_exit_set: assert property (p_exit_set) else $error("exit release missed");
  property p_exit_keep;
    exitTypeReleased |=> exitTypeReleased [*3];
  endproperty
  a_exit_keep: assert property (p_exit_keep) else $error("exit release dropped");
  property p_exit_cause;
    $rose(exitTypeReleased) |-> !$past(resumeResetN) && !$past(platformResetN);
  endproperty
  a_exit_cause: assert property (p_exit_cause) else $error("exit release without both resets");
  property p_excluded;
    railStatus[2].sequenceExcluded == (railStatus[2].sequenceGroup == 4'hf);
  endproperty
  a_excluded: assert property (p_excluded) else $error("exclusion flag wrong");
  property p_direct_mv;
    $past(resetn) && !railStatus[0].linkEnable && railStatus[0].voltageCode inside {[8'h33:8'hd3]}
      |-> railStatus[0].targetMv == BRC_DIRECT_MV_BASE + BRC_STEP_MV * (12'(railStatus[0].voltageCode) - 12'h033);
  endproperty
  a_direct_mv: assert property (p_direct_mv) else $error("direct code voltage wrong");
  property p_sleep_off;
    railStatus[1].linkEnable && railStatus[1].voltageCode == 8'h00 && $past(sleepVoltageOffAtZero)
      |-> !railStatus[1].railOn;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("code zero did not switch off");
  cover property ($rose(exitTypeReleased));
  cover property (regAnswer.valid);
  cover property (railStatus[0].railOn);
endmodule
bind brc_regs brc_properties chk_u (.clk, .resetn, .regRequest, .regAnswer, .resumeResetN, .platformResetN,
  .sleepVoltageOffAtZero, .exitTypeReleased, .railStatus);

//--- brc_host.sv
// Host model issuing single-byte register accesses
`timescale 1ns/100ps
module brc_host
  import brc_pkg::*;
(
  input wire logic clk,
  output brc_pkg::brc_reg_request_type regRequest
);
  initial regRequest = '0;
  // One-cycle strobe, then a quiet cycle so strobes never merge
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    regRequest <= '{wr, !wr, a, v};
    @(negedge clk);
    regRequest <= '0;
  endtask
endmodule

//--- brc_regs_test.sv
// Self-checking bench for the buck rail control register bank
`timescale 1ns/100ps
module brc_regs_test;
  import brc_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  brc_reg_request_type regRequest;
  brc_reg_answer_type regAnswer;
  brc_link_command_type setVoltageCommand = '0;
  logic [2:0] sequencerRequest = 3'h0;
  logic resumeResetN = 1'b1;
  logic platformResetN = 1'b1;
  logic sleepVoltageOffAtZero = 1'b0;
  logic [7:0] maxOutputLimitCode = 8'hd2;
  logic exitTypeReleased;
  brc_rail_status_type [2:0] railStatus;
  logic [7:0] expQ[$];
  logic [7:0] d;
  int mismatches = 0;
  int checked = 0;
  always #20 clk = ~clk;
  brc_host host_u (.clk, .regRequest);
  brc_regs dut_u (.clk, .resetn, .regRequest, .regAnswer, .setVoltageCommand, .sequencerRequest, .resumeResetN,
    .platformResetN, .sleepVoltageOffAtZero, .maxOutputLimitCode, .exitTypeReleased, .railStatus);
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host_u.access(1'b0, a, 8'h00);
  endtask
  task automatic settle;
    repeat (2) @(negedge clk);
  endtask
  task automatic cmd(input logic [7:0] c);
    setVoltageCommand <= '{1'b1, 2'h1, c};
    @(negedge clk);
    setVoltageCommand <= '0;
    settle();
  endtask
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (regAnswer.valid === 1'b1) begin
      if (expQ.size() == 0) begin
        mismatches++;
        $display("BAD t=%0t seen=%h exp=none", $time, regAnswer.data);
      end else begin
        check(12'(regAnswer.data), 12'(expQ.pop_front()));
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(44));
    repeat (20) @(negedge clk);
    resetn <= 1'b1;
    settle();
    for (int i = 0; i < 3; i++) begin
      rd(BRC_CTL_OFS[i], BRC_CTL_RST[i]);
      rd(BRC_VID_OFS[i], BRC_VID_RST[i]);
      rd(BRC_SLEW_OFS[i], BRC_SLEW_RST[i]);
      host_u.access(1'b1, BRC_CTL_OFS[i], 8'hff);
      rd(BRC_CTL_OFS[i], 8'h13);
      host_u.access(1'b1, BRC_SLEW_OFS[i], 8'hff);
      rd(BRC_SLEW_OFS[i], 8'h31);
      host_u.access(1'b1, BRC_SEQ_OFS[i], 8'hff);
      rd(BRC_SEQ_OFS[i], 8'h3f);
      d = 8'($urandom);
      host_u.access(1'b1, BRC_BOOT_OFS[i], d);
      rd(BRC_BOOT_OFS[i], {d[7:1], |d[7:1]});
      host_u.access(1'b1, BRC_BOOT_OFS[i], 8'h01);
      rd(BRC_BOOT_OFS[i], 8'h00);
    end
    host_u.access(1'b1, 8'h10, 8'hff);
    rd(8'h10, 8'h03);
    host_u.access(1'b1, 8'h00, 8'h5a);
    rd(8'h00, 8'h00);
    settle();
    check(12'(railStatus[0].railClass), 12'(BRC_TYPE_A));
    check(12'(railStatus[0].sequenceGroup), 12'h00f);
    check(12'(railStatus[2].railClass), 12'(BRC_TYPE_SX));
    host_u.access(1'b1, 8'h10, 8'h01);
    settle();
    check(12'(railStatus[1].railClass), 12'(BRC_TYPE_SX));
    resumeResetN <= 1'b0;
    settle();
    check(12'(exitTypeReleased), 12'h000);
    check(12'(railStatus[0].railClass), 12'(BRC_TYPE_A));
    platformResetN <= 1'b0;
    settle();
    resumeResetN <= 1'b1;
    platformResetN <= 1'b1;
    settle();
    check(12'(railStatus[0].railClass), 12'(BRC_TYPE_SX));
    $display("register map and exit tests done");
    for (int k = 0; k < 8; k++) begin
      sequencerRequest <= {2'b00, k[2]};
      host_u.access(1'b1, BRC_CTL_OFS[0], {6'h00, 2'(k)});
      settle();
      check(12'(railStatus[0].railOn), 12'(k[1] ? k[0] : k[2]));
    end
    for (int k = 0; k < 4; k++) begin
      host_u.access(1'b1, BRC_SLEW_OFS[1], {2'b00, 2'(k), 3'b000, k[0]});
      d = {2'b00, 2'(k), 4'($urandom)};
      host_u.access(1'b1, BRC_SEQ_OFS[2], d);
      settle();
      check(12'(railStatus[1].fastRate), k == 2 ? 12'h190 : (k == 1 ? 12'h0c8 : 12'h064));
      check(12'(railStatus[1].fastRateReserved), 12'(k == 3));
      check(12'(railStatus[1].slowRate), k[0] ? 12'h032 : 12'h019);
      check(12'(railStatus[2].railClass), 12'(k));
      check(12'(railStatus[2].sequenceExcluded), 12'(d[3:0] == 4'hf));
    end
    $display("on/off, slew and sequencing tests done");
    // Rail 1 still has link, software select and enable set
    cmd(8'h01);
    check(railStatus[1].targetMv, 12'h0fa);
    check(12'(railStatus[1].linkEnable), 12'h001);
    cmd(8'hd3);
    check(12'(railStatus[1].voltageCode), 12'h0d2);
    maxOutputLimitCode <= 8'hd3;
    settle();
    check(railStatus[1].targetMv, 12'h514);
    sleepVoltageOffAtZero <= 1'b1;
    cmd(8'h00);
    check(12'(railStatus[1].railOn), 12'h000);
    sleepVoltageOffAtZero <= 1'b0;
    settle();
    check(railStatus[1].targetMv, 12'h0fa);
    host_u.access(1'b1, BRC_CTL_OFS[1], 8'h03);
    cmd(8'h50);
    rd(BRC_VID_OFS[1], 8'h00);
    host_u.access(1'b1, BRC_VID_OFS[1], 8'h33);
    settle();
    check(railStatus[1].targetMv, 12'h44c);
    check(12'(railStatus[1].linkEnable), 12'h000);
    resetn <= 1'b0;
    settle();
    resetn <= 1'b1;
    settle();
    check(12'(exitTypeReleased), 12'h000);
    $display("voltage link and reset tests done");
    for (int n = 0; n < 20 && expQ.size() > 0; n++) @(negedge clk);
    if (expQ.size() > 0) mismatches++;
    finish_test();
  end
endmodule
